/* rtl/irs_cnt_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface irs_cnt_if;
	logic       load;
	logic [3:0] load_val;
	logic       stall;
	logic       done;
	modport ctl (output load, output load_val, output stall, input done);
	modport cnt (input load, input load_val, input stall, output done);
endinterface
`default_nettype wire

/* rtl/irs_pkg.sv */
`default_nettype none
package irs_pkg;
	localparam int unsigned CLK_MHZ          = 100;
	localparam logic [3:0] PRIO_EXT_STATES   = 4'h2;
	localparam logic [3:0] PRIO_INT_STATES   = 4'h1;
	localparam logic [4:0] WAIT_ONCHIP_MIN   = 5'h01;
	localparam logic [4:0] WAIT_ONCHIP_MAX   = 5'h0D;
	localparam logic [4:0] WAIT_EXT_MIN      = 5'h05;
	localparam logic [4:0] WAIT_EXT_MAX      = 5'h11;
	localparam logic [3:0] SAVE_ONCHIP       = 4'h4;
	localparam logic [3:0] SAVE_EXT          = 4'hC;
	localparam logic [3:0] VEC_ONCHIP        = 4'h2;
	localparam logic [3:0] VEC_EXT           = 4'h6;
	localparam logic [3:0] FETCH_ONCHIP      = 4'h4;
	localparam logic [3:0] FETCH_EXT         = 4'hC;
	localparam logic [3:0] INTERNAL_STATES   = 4'h4;
	localparam logic [15:0] SP_STEP          = 16'h0002;
	localparam int unsigned IMASK_BIT        = 7;
	localparam logic [15:0] VEC_INDEX_SCALE  = 16'h0002;
	typedef enum logic [2:0] {
		IRS_IDLE, IRS_PRIO, IRS_WAIT, IRS_SAVE, IRS_VEC, IRS_FETCH,
		IRS_INTERNAL
	} irs_state_t;
endpackage
`default_nettype wire

/* rtl/irs_sequencer.sv */
// Overview of operation
// - Priority decision lasts two states for external requests, one for internal.
// - Context save waits for the current instruction to end, 1-13 or 5-17 states.
// - Block-move and peripheral transfer instructions may exceed that wait.
// - Save 4/12, vector 2/6, fetch 4/12, internal 4 states, on-chip/external.
// - External wait states lengthen each external save, vector and fetch step.
// - The pushed return address is the pending prefetch address.
// - Code already fetched and the following prefetch are discarded.
// - Vector address is driven, handler address read, first instruction fetched.
// - On-chip accesses move one 16-bit word, one access per stack or vector word.
// - Return address is pushed first, flags second, stack pointer minus two each.
// - Acceptance sets the interrupt mask flag; the non-maskable request stays open.
`timescale 1ns/100ps
`default_nettype none
module irs_sequencer (
	input  wire logic                 SYS_CLK,
	input  wire logic                 SYS_RST,
	input  wire logic                 IRQ_REQ,
	input  wire logic                 IRQ_EXTERNAL,
	input  wire logic                 IRQ_NMI,
	input  wire logic [7:0]           IRQ_VECTOR,
	input  wire logic                 FLAG_MASK,
	input  wire logic                 EXT_MEM,
	input  wire logic                 MEM_WAIT,
	input  wire logic                 INSN_DONE,
	input  wire logic [15:0]          PREFETCH_ADDR,
	input  wire logic [15:0]          STACK_PTR,
	input  wire logic [7:0]           FLAGS_REGISTER,
	input  wire logic [15:0]          READ_DATA,
	output logic                      ACCEPT,
	output logic                      DISCARD_PREFETCH,
	output logic [15:0]               ADDR,
	output logic [15:0]               WRITE_DATA,
	output logic                      READ_EN,
	output logic                      WRITE_EN,
	output logic [15:0]               NEW_SP,
	output logic [7:0]                NEW_FLAGS,
	output logic [15:0]               HANDLER_PC,
	output logic                      HANDLER_START,
	output logic [7:0]                LATENCY
);
	import irs_pkg::*;

	// ********************************************
	// Step lengths
	// ********************************************
	function automatic logic [3:0] step_len(input irs_state_t s,
		input logic ext);
		case (s)
			IRS_SAVE:  step_len = ext ? SAVE_EXT : SAVE_ONCHIP;
			IRS_VEC:   step_len = ext ? VEC_EXT : VEC_ONCHIP;
			IRS_FETCH: step_len = ext ? FETCH_EXT : FETCH_ONCHIP;
			default:   step_len = INTERNAL_STATES;
		endcase
	endfunction

	irs_cnt_if cif ();
	irs_step_counter u_cnt (
		.SYS_CLK (SYS_CLK),
		.SYS_RST (SYS_RST),
		.cif     (cif.cnt)
	);

	irs_state_t  state, next_state;
	logic        ext, next_ext;
	logic [15:0] sp, next_sp;
	logic [15:0] ret_pc, next_ret_pc;
	logic [7:0]  flags, next_flags;
	logic [7:0]  vec, next_vec;
	logic [15:0] hpc, next_hpc;
	logic [7:0]  lat, next_lat;
	logic [7:0]  lat_out, next_lat_out;
	logic        start, next_start;
	logic        word_idx, next_word_idx;
	logic        accepting;

	// Masked requests are ignored; the non-maskable one always passes
	assign accepting = IRQ_REQ && (IRQ_NMI || !FLAG_MASK);

	// ********************************************
	// Sequencer
	// ********************************************
	always_comb begin
		next_state    = state;
		next_ext      = ext;
		next_sp       = sp;
		next_ret_pc   = ret_pc;
		next_flags    = flags;
		next_vec      = vec;
		next_hpc      = hpc;
		next_lat      = (state == IRS_IDLE) ? 8'h00 : lat + 8'h01;
		next_lat_out  = lat_out;
		next_start    = 1'b0;
		next_word_idx = word_idx;
		cif.load      = 1'b0;
		cif.load_val  = 4'h0;
		cif.stall     = 1'b0;
		case (state)
			IRS_IDLE: begin
				if (accepting) begin
					next_state   = IRS_PRIO;
					next_vec     = IRQ_VECTOR;
					cif.load     = 1'b1;
					cif.load_val = IRQ_EXTERNAL ? PRIO_EXT_STATES
						: PRIO_INT_STATES;
				end
			end
			IRS_PRIO: if (cif.done) next_state = IRS_WAIT;
			IRS_WAIT: begin
				// Wait has no timer: long block transfers simply hold here
				if (INSN_DONE) begin
					next_state    = IRS_SAVE;
					next_ext      = EXT_MEM;
					next_ret_pc   = PREFETCH_ADDR;
					next_sp       = STACK_PTR;
					next_flags    = FLAGS_REGISTER;
					next_word_idx = 1'b0;
					cif.load      = 1'b1;
					cif.load_val  = step_len(IRS_SAVE, EXT_MEM);
				end
			end
			IRS_SAVE, IRS_VEC, IRS_FETCH, IRS_INTERNAL: begin
				cif.stall = ext && MEM_WAIT && state != IRS_INTERNAL;
				if (state == IRS_SAVE && !cif.stall && !word_idx &&
					cif.done == 1'b0) begin
					next_word_idx = 1'b1;
				end
				if (state == IRS_VEC && READ_EN && !cif.stall) begin
					next_hpc = READ_DATA;
				end
				if (cif.done) begin
					case (state)
						IRS_SAVE: begin
							next_state = IRS_VEC;
							next_sp    = sp - SP_STEP - SP_STEP;
							next_flags = flags | (8'h01 << IMASK_BIT);
						end
						IRS_VEC:   next_state = IRS_FETCH;
						IRS_FETCH: next_state = IRS_INTERNAL;
						default: begin
							next_state   = IRS_IDLE;
							next_start   = 1'b1;
							next_lat_out = lat + 8'h01;
						end
					endcase
					if (state != IRS_INTERNAL) begin
						cif.load     = 1'b1;
						cif.load_val = step_len(
							state == IRS_SAVE ? IRS_VEC :
							state == IRS_VEC ? IRS_FETCH : IRS_INTERNAL, ext);
					end
				end
			end
			default: next_state = IRS_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state    <= IRS_IDLE;
			ext      <= 1'b0;
			sp       <= 16'h0000;
			ret_pc   <= 16'h0000;
			flags    <= 8'h00;
			vec      <= 8'h00;
			hpc      <= 16'h0000;
			lat      <= 8'h00;
			lat_out  <= 8'h00;
			start    <= 1'b0;
			word_idx <= 1'b0;
		end else begin
			state    <= next_state;
			ext      <= next_ext;
			sp       <= next_sp;
			ret_pc   <= next_ret_pc;
			flags    <= next_flags;
			vec      <= next_vec;
			hpc      <= next_hpc;
			lat      <= next_lat;
			lat_out  <= next_lat_out;
			start    <= next_start;
			word_idx <= next_word_idx;
		end
	end

	// ********************************************
	// Bus drive
	// ********************************************
	// One word per access: PC word at SP-2, then flags word at SP-4
	always_comb begin
		ADDR       = 16'h0000;
		WRITE_DATA = 16'h0000;
		READ_EN    = 1'b0;
		WRITE_EN   = 1'b0;
		case (state)
			IRS_SAVE: begin
				WRITE_EN = 1'b1;
				if (!word_idx) begin
					ADDR       = sp - SP_STEP;
					WRITE_DATA = ret_pc;
				end else begin
					ADDR       = sp - SP_STEP - SP_STEP;
					WRITE_DATA = {flags, flags};
				end
			end
			IRS_VEC: begin
				READ_EN = 1'b1;
				ADDR    = {8'h00, vec} * VEC_INDEX_SCALE;
			end
			IRS_FETCH: begin
				READ_EN = 1'b1;
				ADDR    = hpc;
			end
			default: ;
		endcase
	end

	assign ACCEPT           = state == IRS_PRIO;
	assign DISCARD_PREFETCH = state == IRS_SAVE;
	assign NEW_SP           = sp;
	assign NEW_FLAGS        = flags;
	assign HANDLER_PC       = hpc;
	assign HANDLER_START    = start;
	assign LATENCY          = lat_out;

	// ********************************************
	// Checks
	// ********************************************
	property p_prio;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(state == IRS_IDLE && accepting && !IRQ_EXTERNAL) |=> ##1
			state == IRS_WAIT;
	endproperty
	a_prio: assert property (p_prio) else $error("prio len");

	property p_mask;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(state == IRS_VEC) |-> flags[IMASK_BIT];
	endproperty
	a_mask: assert property (p_mask) else $error("mask not set");

	property p_sp;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(state == IRS_WAIT && INSN_DONE) |=> ##[4:300]
			(state == IRS_VEC && sp == $past(STACK_PTR, 1) - 16'h0004);
	endproperty
	a_sp: assert property (p_sp) else $error("stack ptr");

	property p_ret;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(state == IRS_WAIT && INSN_DONE) |=>
			(WRITE_EN && WRITE_DATA == $past(PREFETCH_ADDR) &&
			ADDR == $past(STACK_PTR) - SP_STEP);
	endproperty
	a_ret: assert property (p_ret) else $error("return addr");

	sequence s_take_ext;
		state == IRS_IDLE && accepting && IRQ_EXTERNAL;
	endsequence

	sequence s_prio_two;
		(ACCEPT) [*2] ##1 !ACCEPT;
	endsequence

	property p_prio_ext;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		s_take_ext |=> s_prio_two;
	endproperty
	a_prio_ext: assert property (p_prio_ext) else $error("ext prio len");

	property p_discard;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(state == IRS_WAIT && INSN_DONE) |=> (DISCARD_PREFETCH && WRITE_EN);
	endproperty
	a_discard: assert property (p_discard) else $error("no discard");

	sequence s_fetch_end;
		state == IRS_FETCH && cif.done;
	endsequence

	sequence s_internal_run;
		(!HANDLER_START) [*4] ##1 HANDLER_START;
	endsequence

	property p_internal;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		s_fetch_end |=> s_internal_run;
	endproperty
	a_internal: assert property (p_internal) else $error("internal len");
endmodule
`default_nettype wire

/* rtl/irs_step_counter.sv */
`timescale 1ns/100ps
`default_nettype none
module irs_step_counter (
	input  wire logic SYS_CLK,
	input  wire logic SYS_RST,
	irs_cnt_if.cnt    cif
);
	logic [3:0] count;
	logic [3:0] next_count;

	// Stall holds the count so external wait states lengthen the step
	always_comb begin
		next_count = count;
		if (cif.load) begin
			next_count = cif.load_val;
		end else if (!cif.stall && count != 4'h0) begin
			next_count = count - 4'h1;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			count <= 4'h0;
		end else begin
			count <= next_count;
		end
	end

	// Done must not look at load: the step logic raises load from done
	assign cif.done = !cif.stall && count == 4'h1;
endmodule
`default_nettype wire

/* tb/irs_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ********************
// Core bus side
// ********************
module irs_core_model (
	input  wire logic        SYS_CLK,
	input  wire logic        ACCEPT,
	input  wire logic [15:0] ADDR,
	input  wire logic [15:0] WRITE_DATA,
	input  wire logic        READ_EN,
	input  wire logic        WRITE_EN,
	input  wire logic [4:0]  WAIT_LEN,
	output logic             INSN_DONE,
	output logic [15:0]      READ_DATA,
	output logic [15:0]      WA0,
	output logic [15:0]      WD0,
	output logic [15:0]      WA1,
	output logic [15:0]      WD1,
	output logic [15:0]      RA
);
	logic       armed = 1'b0;
	logic       got   = 1'b0;
	logic       fin   = 1'b0;
	logic [4:0] cnt   = 5'h00;
	// Any wait length, also beyond the usual bound
	// Launched on the falling edge so it stands at the sampling edge
	assign INSN_DONE = fin;
	// One word per access; idle bus moves so stale data cannot match
	assign READ_DATA = READ_EN ? {8'h40, ADDR[7:0]} : ~ADDR;
	always @(negedge SYS_CLK) begin
		if (ACCEPT) begin
			armed <= 1'b1;
			fin <= 1'b0;
			cnt <= 5'h00;
			got <= 1'b0;
		end else if (armed) begin
			if (cnt == WAIT_LEN - 5'h01) begin
				fin <= 1'b1;
				armed <= 1'b0;
			end else
				cnt <= cnt + 5'h01;
		end else
			fin <= 1'b0;
		if (WRITE_EN && !got) begin
			got <= 1'b1;
			WA0 <= ADDR;
			WD0 <= WRITE_DATA;
		end
		if (WRITE_EN) begin
			WA1 <= ADDR;
			WD1 <= WRITE_DATA;
		end
		if (READ_EN)
			RA <= ADDR;
	end
endmodule
`default_nettype wire

/* tb/tb_interrupt_response_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
// ********************
// Sequencer bench
// ********************
module tb_interrupt_response_sequencer;
	logic        sys_clk = 1'b0, sys_rst = 1'b1, irq_req = 1'b0;
	logic        irq_ext = 1'b0, irq_nmi = 1'b0, flag_mask = 1'b0;
	logic        ext_mem = 1'b0, mem_wait = 1'b0, insn_done;
	logic [7:0]  irq_vec = 8'h0A, flags = 8'h05, new_flags, latency;
	logic [15:0] pf_addr = 16'h1234, sp = 16'hFF80, rd_data, addr;
	logic [15:0] wr_data, new_sp, handler_pc, wa0, wd0, wa1, wd1, ra;
	logic        accept, discard, rd_en, wr_en, handler_start;
	logic [4:0]  wait_len = 5'h01;
	int          fail_count = 0, samples_checked = 0;
	irs_sequencer i_irs_sequencer (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
		.IRQ_REQ(irq_req), .IRQ_EXTERNAL(irq_ext), .IRQ_NMI(irq_nmi),
		.IRQ_VECTOR(irq_vec), .FLAG_MASK(flag_mask), .EXT_MEM(ext_mem),
		.MEM_WAIT(mem_wait), .INSN_DONE(insn_done), .PREFETCH_ADDR(pf_addr),
		.STACK_PTR(sp), .FLAGS_REGISTER(flags), .READ_DATA(rd_data),
		.ACCEPT(accept), .DISCARD_PREFETCH(discard), .ADDR(addr),
		.WRITE_DATA(wr_data), .READ_EN(rd_en), .WRITE_EN(wr_en),
		.NEW_SP(new_sp), .NEW_FLAGS(new_flags), .HANDLER_PC(handler_pc),
		.HANDLER_START(handler_start), .LATENCY(latency));
	irs_core_model i_irs_core_model (.SYS_CLK(sys_clk), .ACCEPT(accept),
		.ADDR(addr), .WRITE_DATA(wr_data), .READ_EN(rd_en), .WRITE_EN(wr_en),
		.WAIT_LEN(wait_len), .INSN_DONE(insn_done), .READ_DATA(rd_data),
		.WA0(wa0), .WD0(wd0), .WA1(wa1), .WD1(wd1), .RA(ra));
	initial forever #5 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Called at a falling edge; returns at the handler start cycle
	task automatic run(input logic ext, mem, input logic [4:0] w,
		input logic stall);
		int n = 0;
		int k = 0;
		logic dis = 1'b0;
		logic [15:0] exp;
		logic [15:0] hp;
		irq_vec = irq_vec + 8'h03;
		pf_addr = pf_addr + 16'h0102;
		sp = sp - 16'h0010;
		hp = {8'h40, irq_vec[6:0], 1'b0};
		exp = (ext ? 16'h0002 : 16'h0001) + (mem ? 16'h0022 : 16'h000E);
		exp = exp + 16'(w) + (stall ? 16'h0003 : 16'h0000);
		irq_ext = ext;
		ext_mem = mem;
		wait_len = w;
		irq_req = 1'b1;
		while (n < 200) begin
			@(negedge sys_clk);
			if (handler_start === 1'b1)
				break;
			if (accept === 1'b1)
				irq_req = 1'b0;
			if (discard === 1'b1)
				dis = 1'b1;
			mem_wait = stall && (wr_en === 1'b1) && k < 3;
			if (mem_wait)
				k++;
			n++;
		end
		chk("states", 16'(n), exp);
		chk("latency", {8'h00, latency}, exp);
		chk("handler_pc", handler_pc, hp);
		chk("first_fetch", ra, hp);
		chk("new_sp", new_sp, sp - 16'h0004);
		chk("new_flags", {8'h00, new_flags}, {8'h00, flags | 8'h80});
		chk("push0_addr", wa0, sp - 16'h0002);
		chk("push0_data", wd0, pf_addr);
		chk("push1_addr", wa1, sp - 16'h0004);
		chk("push1_data", wd1, {flags, flags});
		chk("discard", {15'h0000, dis}, 16'h0001);
	endtask
	task automatic s_onchip();
		run(1'b0, 1'b0, 5'h01, 1'b0);
		run(1'b1, 1'b0, 5'h0D, 1'b0); // back to back, no idle gap
	endtask
	task automatic s_external();
		run(1'b0, 1'b1, 5'h05, 1'b0);
		run(1'b1, 1'b1, 5'h11, 1'b1); // wait states stretch the save step
	endtask
	task automatic s_masked();
		flag_mask = 1'b1;
		irq_req = 1'b1;
		repeat (8) begin
			@(negedge sys_clk);
			chk("masked", {15'h0000, accept}, 16'h0000);
		end
		irq_nmi = 1'b1;
		run(1'b0, 1'b0, 5'h03, 1'b0);
		irq_nmi = 1'b0;
		flag_mask = 1'b0;
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		s_onchip();
		s_external();
		s_masked();
		tally_and_finish();
	end
	initial begin
		#20000;
		fail_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
